//--- common/dco_pkg.sv
// Constants shared by both ends of the configuration-set link.
// Assumes one clock for both ends and a single task-file bus.
package dco_pkg;
    // =========================================
    // Task-file addresses and codes
    localparam logic [2:0]  TF_DATA    = 3'h0;
    localparam logic [2:0]  TF_FEAT    = 3'h1;
    localparam logic [2:0]  TF_HEAD    = 3'h6;
    localparam logic [2:0]  TF_CMD     = 3'h7;
    localparam logic [7:0]  CMD_OPCODE = 8'hb1;
    localparam logic [7:0]  SUB_SET    = 8'h03;
    localparam int          DRV_BIT    = 4;
    // =========================================
    // Overlay layout
    localparam logic [15:0] STRUCT_REV = 16'h0001;
    localparam logic [7:0]  W_REV      = 8'h00;
    localparam logic [7:0]  W_MW       = 8'h01;
    localparam logic [7:0]  W_UDMA     = 8'h02;
    localparam logic [7:0]  W_FEAT     = 8'h07;
    localparam logic [7:0]  W_LAST     = 8'hff;
    localparam int          MW_TOP     = 2;
    localparam int          UD_TOP     = 5;
    localparam int          HPA_BIT    = 7;
    // =========================================
    // Full capability set, also the reset value
    localparam logic [15:0] MW_CAP     = 16'h0007;
    localparam logic [15:0] UDMA_CAP   = 16'h003f;
    localparam logic [15:0] FEAT_CAP   = 16'h008f;
    // =========================================
    // Host APB register offsets and bits
    localparam logic [7:0]  A_CTRL     = 8'h00;
    localparam logic [7:0]  A_STAT     = 8'h04;
    localparam logic [7:0]  A_MW       = 8'h08;
    localparam logic [7:0]  A_UDMA     = 8'h0c;
    localparam logic [7:0]  A_FEAT     = 8'h10;
    localparam int          ST_BUSY    = 0;
    localparam int          ST_DONE    = 1;
    localparam int          ST_ABRT    = 2;
    // =========================================
    // States
    typedef enum logic [1:0] {DS_IDLE, DS_RECV, DS_CHECK} dco_dstate_e;
    typedef enum logic [2:0] {
        HS_IDLE, HS_FEAT, HS_HEAD, HS_CMD, HS_WDRQ, HS_SEND, HS_WDONE
    } dco_hstate_e;
endpackage

//--- common/dco_if.sv
// Task-file link between the host controller and the drive.
// Assumes both ends run on the same clock; no tristate here.
`timescale 1ns/1ns
interface dco_if;
    logic        tf_wr;     // One-cycle register write strobe
    logic [2:0]  tf_addr;   // Task-file register address
    logic [15:0] tf_wdata;  // Write data
    logic        dev_busy;  // Device executing
    logic        dev_drq;   // Device wants overlay words
    logic        dev_err;   // Last command aborted
    logic        dev_done;  // One-cycle completion pulse
    modport host (output tf_wr, tf_addr, tf_wdata,
                  input  dev_busy, dev_drq, dev_err, dev_done);
    modport device (input  tf_wr, tf_addr, tf_wdata,
                    output dev_busy, dev_drq, dev_err, dev_done);
endinterface

//--- rtl/dco_device.sv
// Drive end: decodes the configuration-set command, takes the
// overlay and narrows the reported DMA and feature capabilities.
// Assumes the host keeps to the task-file order on the link.
// What this block does
// - Command B1h with subcommand 03h starts it
// - Drive-select bit picks device; others ignore
// - Capabilities may only shrink, never grow
// - Overlay modifies identify capability words
// - Cleared bits drop support afterwards
// - Set bits outside capability set ignored, except Ultra bits 15:6, which abort
// - Host puts revision 0001h in word 0
// - Multiword 2 kept while mode 2 selected
// - Multiword 1 kept if 2 supported/selected
// - Multiword mode 0 bit never cleared
// - Ultra reserved zero; 5 kept if selected
// - Ultra 4 kept if 5 supported/selected
// - Ultra 3 kept if 5,4 supported/selected
// - Frozen configuration aborts every set command
// - Protected area established blocks clearing bit
`timescale 1ns/1ns
module dco_device #(
    parameter logic DEV_SEL = 1'b0  // 0 first_device, 1 second_device
) (
    input  wire logic        pclk,            // Clock
    input  wire logic        presetn,         // Async reset, low
    dco_if.device            tf,              // Task-file link
    input  wire logic        freeze_locked,   // Freeze lock held
    input  wire logic        hpa_set,         // Protected area set
    input  wire logic        mw_sel_valid,    // A multiword mode in use
    input  wire logic [1:0]  mw_sel,          // Selected multiword mode
    input  wire logic        udma_sel_valid,  // An Ultra mode in use
    input  wire logic [2:0]  udma_sel,        // Selected Ultra mode
    output logic      [15:0] mw_word,         // Reported multiword word
    output logic      [15:0] udma_word,       // Reported Ultra word
    output logic      [15:0] feat_word        // Reported feature word
);
    import dco_pkg::*;

    dco_dstate_e state_reg;
    logic [7:0]  feat_reg;
    logic [7:0]  head_reg;
    logic [7:0]  cnt_reg;
    logic [15:0] ov_rev_reg;
    logic [15:0] ov_mw_reg;
    logic [15:0] ov_ud_reg;
    logic [15:0] ov_ft_reg;
    logic [15:0] mw_reg;
    logic [15:0] ud_reg;
    logic [15:0] ft_reg;
    logic        busy_reg;
    logic        drq_reg;
    logic        err_reg;
    logic        done_reg;
    logic        cmd_hit;
    logic        data_wr;
    logic        bad;
    logic [15:0] mw_next;
    logic [15:0] ud_next;
    logic [15:0] ft_next;

    // =========================================
    // Command decode
    // Selected-mode test shared by both DMA words
    function automatic logic sel_ge(input logic v, input logic [2:0] s,
                                    input int i);
        sel_ge = v && (int'(s) >= i);
    endfunction

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            feat_reg <= 8'h00;
            head_reg <= 8'h00;
        end
        else if (tf.tf_wr && state_reg == DS_IDLE)
        begin
            if (tf.tf_addr == TF_FEAT)
                feat_reg <= tf.tf_wdata[7:0];
            if (tf.tf_addr == TF_HEAD)
                head_reg <= tf.tf_wdata[7:0];
        end
    end

    // Only the addressed drive answers
    assign cmd_hit = tf.tf_wr && state_reg == DS_IDLE
                     && tf.tf_addr == TF_CMD
                     && tf.tf_wdata[7:0] == CMD_OPCODE
                     && feat_reg == SUB_SET
                     && head_reg[DRV_BIT] == DEV_SEL;
    assign data_wr = tf.tf_wr && state_reg == DS_RECV
                     && tf.tf_addr == TF_DATA;

    // =========================================
    // Sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= DS_IDLE;
            busy_reg  <= 1'b0;
            drq_reg   <= 1'b0;
            err_reg   <= 1'b0;
            done_reg  <= 1'b0;
        end
        else
        begin
            done_reg <= 1'b0;
            case (state_reg)
                DS_IDLE:
                    if (cmd_hit)
                    begin
                        err_reg <= 1'b0;
                        if (freeze_locked)
                        begin
                            err_reg  <= 1'b1;
                            done_reg <= 1'b1;
                        end
                        else
                        begin
                            state_reg <= DS_RECV;
                            busy_reg  <= 1'b1;
                            drq_reg   <= 1'b1;
                        end
                    end
                DS_RECV:
                    if (data_wr && cnt_reg == W_LAST)
                    begin
                        state_reg <= DS_CHECK;
                        drq_reg   <= 1'b0;
                    end
                DS_CHECK:
                begin
                    state_reg <= DS_IDLE;
                    busy_reg  <= 1'b0;
                    err_reg   <= bad;
                    done_reg  <= 1'b1;
                end
                default:
                    state_reg <= DS_IDLE;
            endcase
        end
    end

    // =========================================
    // Overlay capture; only the words that matter are kept
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg    <= 8'h00;
            ov_rev_reg <= 16'h0000;
            ov_mw_reg  <= 16'h0000;
            ov_ud_reg  <= 16'h0000;
            ov_ft_reg  <= 16'h0000;
        end
        else if (cmd_hit)
            cnt_reg <= 8'h00;
        else if (data_wr)
        begin
            cnt_reg <= cnt_reg + 8'h01;
            case (cnt_reg)
                W_REV:   ov_rev_reg <= tf.tf_wdata;
                W_MW:    ov_mw_reg  <= tf.tf_wdata;
                W_UDMA:  ov_ud_reg  <= tf.tf_wdata;
                W_FEAT:  ov_ft_reg  <= tf.tf_wdata;
                default: ;
            endcase
        end
    end

    // =========================================
    // Legality check of the proposed words
    always_comb
    begin
        logic        hi;
        logic [15:0] mw_clr;
        logic [15:0] ud_clr;
        hi  = 1'b0;
        // Bits outside the full set keep their value
        mw_next = mw_reg & (ov_mw_reg | ~MW_CAP);
        ud_next = ud_reg & (ov_ud_reg | ~UDMA_CAP);
        ft_next = ft_reg & (ov_ft_reg | ~FEAT_CAP);
        mw_clr  = mw_reg & ~mw_next;
        ud_clr  = ud_reg & ~ud_next;
        bad     = (ov_rev_reg != STRUCT_REV);
        if (mw_clr[0])
            bad = 1'b1;
        for (int i = 1; i <= MW_TOP; i++)
        begin
            hi = 1'b0;
            for (int j = i + 1; j <= MW_TOP; j++)
                hi = hi | mw_next[j];
            if (mw_clr[i] && (hi || sel_ge(mw_sel_valid, {1'b0, mw_sel}, i)))
                bad = 1'b1;
        end
        for (int i = 0; i <= UD_TOP; i++)
        begin
            hi = 1'b0;
            for (int j = i + 1; j <= UD_TOP; j++)
                hi = hi | ud_next[j];
            if (ud_clr[i] && (hi || sel_ge(udma_sel_valid, udma_sel, i)))
                bad = 1'b1;
        end
        if (|ov_ud_reg[15:UD_TOP+1])
            bad = 1'b1;
        if (hpa_set && ft_reg[HPA_BIT] && !ft_next[HPA_BIT])
            bad = 1'b1;
    end

    // =========================================
    // Reported capability words
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mw_reg <= MW_CAP;
            ud_reg <= UDMA_CAP;
            ft_reg <= FEAT_CAP;
        end
        else if (state_reg == DS_CHECK && !bad)
        begin
            mw_reg <= mw_next;
            ud_reg <= ud_next;
            ft_reg <= ft_next;
        end
    end

    assign mw_word     = mw_reg;
    assign udma_word   = ud_reg;
    assign feat_word   = ft_reg;
    assign tf.dev_busy = busy_reg;
    assign tf.dev_drq  = drq_reg;
    assign tf.dev_err  = err_reg;
    assign tf.dev_done = done_reg;
endmodule

//--- rtl/dco_host.sv
// Host end: APB-programmed controller that issues the
// configuration-set command and streams the overlay block.
// Assumes an APB master and a drive on the same clock.
`timescale 1ns/1ns
module dco_host (
    input  wire logic        pclk,     // Clock
    input  wire logic        presetn,  // Async reset, low
    input  wire logic        psel,     // APB select
    input  wire logic        penable,  // APB access phase
    input  wire logic        pwrite,   // APB write
    input  wire logic [7:0]  paddr,    // APB byte address
    input  wire logic [31:0] pwdata,   // APB write data
    output logic      [31:0] prdata,   // APB read data
    output logic             pready,   // APB ready
    output logic             pslverr,  // APB error, unmapped
    dco_if.host              tf        // Task-file link
);
    import dco_pkg::*;

    dco_hstate_e state_reg;
    logic [7:0]  idx_reg;
    logic        drv_reg;
    logic [15:0] mw_reg;
    logic [15:0] ud_reg;
    logic [15:0] ft_reg;
    logic        done_reg;
    logic        abrt_reg;
    logic        wr_reg;
    logic [2:0]  addr_reg;
    logic [15:0] wdata_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        acc;
    logic        start;
    logic        mapped;
    logic [15:0] word;

    // =========================================
    // APB slave, one wait state per transfer
    assign acc    = psel && penable && !pready_reg;
    assign mapped = paddr == A_CTRL || paddr == A_STAT || paddr == A_MW
                    || paddr == A_UDMA || paddr == A_FEAT;
    assign start  = acc && pwrite && paddr == A_CTRL && pwdata[0]
                    && state_reg == HS_IDLE;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h00000000;
            drv_reg     <= 1'b0;
            mw_reg      <= MW_CAP;
            ud_reg      <= UDMA_CAP;
            ft_reg      <= FEAT_CAP;
        end
        else
        begin
            pready_reg  <= acc;
            pslverr_reg <= acc && !mapped;
            prdata_reg  <= 32'h00000000;
            if (acc && !pwrite)
                case (paddr)
                    A_CTRL:  prdata_reg <= {30'h0, drv_reg, 1'b0};
                    A_STAT:  prdata_reg <= {29'h0, abrt_reg, done_reg,
                                            state_reg != HS_IDLE};
                    A_MW:    prdata_reg <= {16'h0, mw_reg};
                    A_UDMA:  prdata_reg <= {16'h0, ud_reg};
                    A_FEAT:  prdata_reg <= {16'h0, ft_reg};
                    default: prdata_reg <= 32'h00000000;
                endcase
            // Settings frozen while a command runs
            if (acc && pwrite && state_reg == HS_IDLE)
                case (paddr)
                    A_CTRL:  drv_reg <= pwdata[1];
                    A_MW:    mw_reg  <= pwdata[15:0];
                    A_UDMA:  ud_reg  <= pwdata[15:0];
                    A_FEAT:  ft_reg  <= pwdata[15:0];
                    default: drv_reg <= drv_reg;
                endcase
        end
    end

    // =========================================
    // Sticky status; a completion beats a write-one clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            done_reg <= 1'b0;
            abrt_reg <= 1'b0;
        end
        else if (state_reg != HS_IDLE && tf.dev_done)
        begin
            done_reg <= 1'b1;
            abrt_reg <= tf.dev_err;
        end
        else if (acc && pwrite && paddr == A_STAT)
        begin
            done_reg <= done_reg && !pwdata[ST_DONE];
            abrt_reg <= abrt_reg && !pwdata[ST_ABRT];
        end
    end

    // =========================================
    // Overlay word for the current index
    always_comb
    begin
        case (idx_reg)
            W_REV:   word = STRUCT_REV;
            W_MW:    word = mw_reg;
            W_UDMA:  word = {10'h000, ud_reg[5:0]};
            W_FEAT:  word = ft_reg;
            default: word = 16'h0000;
        endcase
    end

    // =========================================
    // Command sequencer and task-file drive
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= HS_IDLE;
            idx_reg   <= 8'h00;
            wr_reg    <= 1'b0;
            addr_reg  <= TF_DATA;
            wdata_reg <= 16'h0000;
        end
        else
        begin
            wr_reg <= 1'b0;
            case (state_reg)
                HS_IDLE:
                    if (start)
                        state_reg <= HS_FEAT;
                HS_FEAT:
                begin
                    wr_reg    <= 1'b1;
                    addr_reg  <= TF_FEAT;
                    wdata_reg <= {8'h00, SUB_SET};
                    state_reg <= HS_HEAD;
                end
                HS_HEAD:
                begin
                    wr_reg    <= 1'b1;
                    addr_reg  <= TF_HEAD;
                    wdata_reg <= 16'h0000;
                    wdata_reg[DRV_BIT] <= drv_reg;
                    state_reg <= HS_CMD;
                end
                HS_CMD:
                begin
                    wr_reg    <= 1'b1;
                    addr_reg  <= TF_CMD;
                    wdata_reg <= {8'h00, CMD_OPCODE};
                    idx_reg   <= 8'h00;
                    state_reg <= HS_WDRQ;
                end
                HS_WDRQ:
                    if (tf.dev_done)
                        state_reg <= HS_IDLE;
                    else if (tf.dev_drq)
                        state_reg <= HS_SEND;
                HS_SEND:
                begin
                    wr_reg    <= 1'b1;
                    addr_reg  <= TF_DATA;
                    wdata_reg <= word;
                    idx_reg   <= idx_reg + 8'h01;
                    if (idx_reg == W_LAST)
                        state_reg <= HS_WDONE;
                end
                HS_WDONE:
                    if (tf.dev_done)
                        state_reg <= HS_IDLE;
                default:
                    state_reg <= HS_IDLE;
            endcase
        end
    end

    assign tf.tf_wr    = wr_reg;
    assign tf.tf_addr  = addr_reg;
    assign tf.tf_wdata = wdata_reg;
    assign prdata      = prdata_reg;
    assign pready      = pready_reg;
    assign pslverr     = pslverr_reg;
endmodule

//--- verification/dco_link_chk.sv
// Checker for the task-file link between host and drive ends.
// Assumes both ends are design modules on one clock.
`timescale 1ns/1ns
module dco_link_chk
    import dco_pkg::*;
#(
    parameter logic DEV_SEL = 1'b0  // Drive this device answers as
) (
    input wire logic        pclk,      // Clock
    input wire logic        presetn,   // Async reset, low
    input wire logic        tf_wr,     // Write strobe
    input wire logic [2:0]  tf_addr,   // Register address
    input wire logic [15:0] tf_wdata,  // Write data
    input wire logic        dev_busy,  // Device busy
    input wire logic        dev_drq,   // Data request
    input wire logic        dev_err,   // Abort flag
    input wire logic        dev_done   // Completion pulse
);
    logic [7:0] sub_reg;
    logic [7:0] head_reg;
    logic [7:0] wcnt_reg;
    logic       cmd_wr;
    logic       data_wr;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ========================================
    // Helper state
    assign cmd_wr  = tf_wr && tf_addr == TF_CMD && tf_wdata[7:0] == CMD_OPCODE && !dev_busy;
    assign data_wr = tf_wr && tf_addr == TF_DATA && dev_drq;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sub_reg  <= 8'h00;
            head_reg <= 8'h00;
        end
        else if (tf_wr && !dev_busy)
        begin
            if (tf_addr == TF_FEAT)
                sub_reg <= tf_wdata[7:0];
            if (tf_addr == TF_HEAD)
                head_reg <= tf_wdata[7:0];
        end
    end

    // Wraps to zero exactly when a whole block has passed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wcnt_reg <= 8'h00;
        else if (data_wr)
            wcnt_reg <= wcnt_reg + 8'h01;
    end

    // ========================================
    // Properties
    chk_cmd_accept: assert property (cmd_wr && sub_reg == SUB_SET
        && head_reg[DRV_BIT] == DEV_SEL
        |=> (dev_busy && dev_drq) || (dev_done && dev_err)) else $error("command not taken");
    chk_other_drive: assert property (cmd_wr && head_reg[DRV_BIT] != DEV_SEL
        |=> !dev_busy && !dev_done) else $error("other drive command acted on");
    chk_host_order: assert property (tf_wr && tf_addr == TF_FEAT && tf_wdata[7:0] == SUB_SET
        |=> tf_wr && tf_addr == TF_HEAD
        ##1 tf_wr && tf_addr == TF_CMD && tf_wdata[7:0] == CMD_OPCODE)
        else $error("command sequence out of order");
    chk_drq_count: assert property ($fell(dev_drq) |-> wcnt_reg == 8'h00)
        else $error("block length not 256 words");
    chk_last_word: assert property (data_wr && wcnt_reg == 8'hff |=> !dev_drq ##1 dev_done)
        else $error("no completion after last word");
    chk_data_gated: assert property (tf_wr && tf_addr == TF_DATA |-> dev_drq)
        else $error("data written without request");
    chk_rev_first: assert property (data_wr && wcnt_reg == 8'h00 |-> tf_wdata == STRUCT_REV)
        else $error("first word not revision");
    chk_ud_resvd: assert property (data_wr && wcnt_reg == W_UDMA |-> ~|tf_wdata[15:6])
        else $error("ultra reserved bits set");
    chk_drq_busy: assert property (dev_drq |-> dev_busy)
        else $error("request outside busy");
    chk_done_pulse: assert property (dev_done |=> !dev_done && !dev_drq)
        else $error("completion not a single pulse");
    chk_busy_end: assert property ($fell(dev_busy) |-> dev_done || $past(dev_done))
        else $error("busy ended without completion");
    chk_err_holds: assert property ($fell(dev_err) |-> $past(cmd_wr) || $past(cmd_wr, 2))
        else $error("abort flag dropped early");
endmodule

//--- verification/dev_config_set_overlay_tb_top.sv
// Testbench: APB master on the host end, mode inputs on the drive end.
// Assumes both ends share one clock and face each other over dco_if.
`timescale 1ns/1ns
module dev_config_set_overlay_tb_top;
    import dco_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        frz, hpa, mv, uv;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0]  msel;
    logic [2:0]  usel;
    logic [15:0] mw_word, udma_word, feat_word;
    int          bad_count, num_checks;

    dco_if link ();
    dco_host dco_host_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .tf(link.host));
    dco_device #(.DEV_SEL(1'b0)) dco_device_i (.pclk, .presetn, .tf(link.device),
        .freeze_locked(frz), .hpa_set(hpa), .mw_sel_valid(mv), .mw_sel(msel),
        .udma_sel_valid(uv), .udma_sel(usel), .mw_word, .udma_word, .feat_word);
    dco_link_chk #(.DEV_SEL(1'b0)) dco_link_chk_i (.pclk, .presetn,
        .tf_wr(link.tf_wr), .tf_addr(link.tf_addr), .tf_wdata(link.tf_wdata),
        .dev_busy(link.dev_busy), .dev_drq(link.dev_drq), .dev_err(link.dev_err),
        .dev_done(link.dev_done));

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // ========================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk(n, 2, "access cycles");
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp, what);
    endtask

    task automatic words(input logic [15:0] m, input logic [15:0] u, input logic [15:0] f);
        chk({16'h0, mw_word}, {16'h0, m}, "mw word");
        chk({16'h0, udma_word}, {16'h0, u}, "udma word");
        chk({16'h0, feat_word}, {16'h0, f}, "feat word");
    endtask

    task automatic modes(input logic a, input logic [1:0] b, input logic c, input logic [2:0] d,
                         input logic h, input logic f);
        {mv, msel, uv, usel, hpa, frz} <= {a, b, c, d, h, f};
    endtask

    task automatic run_set(input logic [15:0] m, input logic [15:0] u, input logic [15:0] f,
                           input logic ab, input logic [15:0] em, input logic [15:0] eu,
                           input logic [15:0] ef);
        logic [31:0] r;
        logic        e;
        int          n;
        wr(A_MW, {16'h0, m});
        wr(A_UDMA, {16'h0, u});
        wr(A_FEAT, {16'h0, f});
        wr(A_CTRL, 32'h1);
        while (r[ST_DONE] !== 1'b1 && n < 200)
        begin
            apb(1'b0, A_STAT, 32'h0, r, e);
            n++;
        end
        chk(r, {29'h0, ab, 2'b10}, "status");
        words(em, eu, ef);
        wr(A_STAT, 32'h6);
    endtask

    task automatic bad(input logic [15:0] m, input logic [15:0] u, input logic [15:0] f);
        run_set(m, u, f, 1'b1, MW_CAP, UDMA_CAP, FEAT_CAP);
    endtask

    // ========================================
    // Scenarios
    task automatic t_reset();
        logic [31:0] r;
        logic        e;
        rd_chk(A_MW, {16'h0, MW_CAP}, "mw reg");
        rd_chk(A_UDMA, {16'h0, UDMA_CAP}, "udma reg");
        rd_chk(A_FEAT, {16'h0, FEAT_CAP}, "feat reg");
        apb(1'b0, 8'h40, 32'h0, r, e);
        chk({31'h0, e}, 32'h1, "unmapped error");
        chk(r, 32'h0, "unmapped data");
        words(MW_CAP, UDMA_CAP, FEAT_CAP);
        $display("test reset done");
    endtask

    task automatic t_illegal();
        modes(1'b1, 2'd2, 1'b0, 3'd0, 1'b0, 1'b0);
        bad(16'h0003, UDMA_CAP, FEAT_CAP);
        modes(1'b0, 2'd0, 1'b0, 3'd0, 1'b0, 1'b0);
        bad(16'h0005, UDMA_CAP, FEAT_CAP);
        modes(1'b1, 2'd1, 1'b0, 3'd0, 1'b0, 1'b0);
        bad(16'h0001, UDMA_CAP, FEAT_CAP);
        bad(16'h0006, UDMA_CAP, FEAT_CAP);
        modes(1'b0, 2'd0, 1'b1, 3'd5, 1'b0, 1'b0);
        bad(MW_CAP, 16'h001f, FEAT_CAP);
        run_set(MW_CAP, 16'h007f, FEAT_CAP, 1'b0, MW_CAP, UDMA_CAP, FEAT_CAP);
        bad(MW_CAP, 16'h002f, FEAT_CAP);
        modes(1'b0, 2'd0, 1'b1, 3'd4, 1'b0, 1'b0);
        bad(MW_CAP, 16'h000f, FEAT_CAP);
        bad(MW_CAP, 16'h0037, FEAT_CAP);
        modes(1'b0, 2'd0, 1'b1, 3'd3, 1'b0, 1'b0);
        bad(MW_CAP, 16'h0007, FEAT_CAP);
        modes(1'b0, 2'd0, 1'b0, 3'd0, 1'b1, 1'b0);
        bad(MW_CAP, UDMA_CAP, 16'h000f);
        modes(1'b0, 2'd0, 1'b0, 3'd0, 1'b0, 1'b1);
        bad(16'h0003, UDMA_CAP, FEAT_CAP);
        $display("test illegal done");
    endtask

    task automatic t_legal();
        modes(1'b1, 2'd1, 1'b1, 3'd2, 1'b0, 1'b0);
        run_set(16'h0003, 16'h0007, 16'h000f, 1'b0, 16'h0003, 16'h0007, 16'h000f);
        run_set(16'hffff, 16'h003f, 16'hffff, 1'b0, 16'h0003, 16'h0007, 16'h000f);
        modes(1'b1, 2'd0, 1'b1, 3'd0, 1'b0, 1'b0);
        run_set(16'h0001, 16'h0001, 16'h000f, 1'b0, 16'h0001, 16'h0001, 16'h000f);
        $display("test legal done");
    endtask

    // Host stalls waiting for a request that never comes; reset recovers
    task automatic t_other_drive();
        wr(A_CTRL, 32'h3);
        repeat (30) @(posedge pclk);
        chk({31'h0, link.dev_busy}, 32'h0, "other drive busy");
        words(16'h0001, 16'h0001, 16'h000f);
        rd_chk(A_STAT, 32'h1, "host waiting");
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        words(MW_CAP, UDMA_CAP, FEAT_CAP);
        $display("test other_drive done");
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        bad_count  = 0;
        num_checks = 0;
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 8'h00;
        pwdata     = 32'h0;
        frz        = 1'b0;
        hpa        = 1'b0;
        mv         = 1'b0;
        msel       = 2'd0;
        uv         = 1'b0;
        usel       = 3'd0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_illegal();
        t_legal();
        t_other_drive();
        give_verdict();
    end

    // About 4200 cycles are expected
    initial
    begin
        repeat (40000) @(posedge pclk);
        bad_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule
